/* File: cwdp_config_decode.sv */
// Operation
// - Watchdog postscale ratio is two to the power of the 4-bit field.
// - Watchdog enable bit forces watchdog on; else software bit controls it.
// - Reset pin select one gives external reset; zero gives plain input.
// - Secondary oscillator power bit one selects low power, zero high power.
// - At reset, port B analog default sets channels 4..0 analog or digital.
// - Capture/compare 2 routes to port C bit 1 when one, else B bit 3.
// - Debugger bit low enables debugger and takes port B bits 6 and 7.
// - Extended instruction bit enables extension and indexed addressing.
// - Dedicated in-circuit port enable bit turns that port on or off.
// - Large parts: boot codes 11,10 give 4K, 01 gives 2K, 00 gives 1K words.
// - 8-Kbyte parts: codes 11,10 give 1K, 01 gives 512, 00 gives 256 words.
// - 4-Kbyte parts: codes 11,10,01 give 512 words, 00 gives 256 words.
// - Single-bit variants: one gives 2K words, zero gives 1K words.
// - Boot size bits are frozen once boot or block 0 protections are on.
// - Low-voltage programming bit one makes port B bit 5 the entry pin.
// - Stack fault reset bit one lets stack overflow or underflow reset.
// - Each block's read guard bit protects that block when zero.
// - Data EEPROM and boot block read guards protect when zero.
// - Each block's write guard bit blocks writes to it when zero.
// - EEPROM, boot and configuration write guards block writes when zero.
// - Table-read guard low hides a block from reads run in other blocks.
// - Part number is 11 bits split over both ID registers with revision.
// - Both identification registers are read-only and ignore writes.
`timescale 1ns/1ns
module cwdp_config_decode #(
  parameter logic [10:0] PART_NUMBER = 11'h155, // Arbitrary neutral value.
  parameter logic [4:0]  REVISION    = 5'h01    // Arbitrary neutral value.
) (
  input  wire logic               sys_clk,          // 125 MHz system clock
  input  wire logic               rst_n,            // Asynchronous reset, low
  input  wire cwdp_pkg::cwdp_mem_e mem_variant,     // Memory size variant strap
  input  wire logic               cfg_wr,           // Programming write strobe
  input  wire logic               cfg_rd,           // Read strobe
  input  wire logic [7:0]         cfg_addr,         // Configuration word offset
  input  wire logic [7:0]         cfg_wdata,        // Write data
  input  wire logic               watchdog_soft_enable, // Software watchdog bit
  input  wire logic               stack_fault,      // Stack over/underflow event
  input  wire logic               prog_wr_req,      // Memory write request
  input  wire logic [2:0]         prog_wr_area,     // 0-5 block, 6 EE, 7 boot
  input  wire logic               tblrd_req,        // Table read request
  input  wire logic [2:0]         tblrd_src_area,   // Area running the read
  input  wire logic [2:0]         tblrd_dst_area,   // Area being read
  output logic [7:0]              cfg_rdata,        // Read data
  output logic                    cfg_wr_refused,   // Write refused pulse
  output cwdp_pkg::cwdp_dec_s     dec,              // Decoded settings
  output logic                    prog_wr_ok,       // Memory write allowed
  output logic                    tblrd_ok,         // Table read may return data
  output logic                    stack_reset_req   // Stack fault reset pulse
);

  typedef struct packed {
    cwdp_pkg::cwdp_st_e  st;
    cwdp_pkg::cwdp_cfg_s cfg;
    cwdp_pkg::cwdp_dec_s dec;
    logic [7:0]          rdata;
    logic                refused;
    logic                wr_ok;
    logic                rd_ok;
    logic                stk;
  } cwdp_state_s;

  cwdp_state_s state_r;
  cwdp_state_s state_nxt;

  function automatic logic [12:0] boot_size(input cwdp_pkg::cwdp_mem_e v,
                                            input logic [1:0] code);
    logic [12:0] w;
    w = cwdp_pkg::WORDS_1K;
    unique case (v)
      cwdp_pkg::CWDP_MEM_LARGE:
        w = code[1] ? cwdp_pkg::WORDS_4K :
            (code[0] ? cwdp_pkg::WORDS_2K : cwdp_pkg::WORDS_1K);
      cwdp_pkg::CWDP_MEM_8K:
        w = code[1] ? cwdp_pkg::WORDS_1K :
            (code[0] ? cwdp_pkg::WORDS_512 : cwdp_pkg::WORDS_256);
      cwdp_pkg::CWDP_MEM_4K:
        w = (code != 2'h0) ? cwdp_pkg::WORDS_512 : cwdp_pkg::WORDS_256;
      cwdp_pkg::CWDP_MEM_ONE:
        w = code[0] ? cwdp_pkg::WORDS_2K : cwdp_pkg::WORDS_1K;
    endcase
    return w;
  endfunction : boot_size

  // Guard lookup for area codes 0-5 blocks, 6 data EEPROM, 7 boot block.
  function automatic logic guard_bit(input logic [5:0] blk, input logic ee,
                                     input logic boot, input logic [2:0] area);
    logic g;
    g = 1'b1;
    if (area == 3'h7)
    begin
      g = boot;
    end
    else if (area == 3'h6)
    begin
      g = ee;
    end
    else
    begin
      g = blk[area];
    end
    return g;
  endfunction : guard_bit

  function automatic cwdp_pkg::cwdp_dec_s decode(input cwdp_pkg::cwdp_cfg_s c,
                                                 input cwdp_pkg::cwdp_mem_e v);
    cwdp_pkg::cwdp_dec_s d;
    logic [1:0] bb;
    d = '0;
    bb = c.dbgboot[cwdp_pkg::BBSZ_LSB +: 2];
    d.wdog_ratio = 16'h0001 << c.wdog[cwdp_pkg::WDOG_PS_LSB +: 4];
    d.ext_reset_en = c.rstpin[cwdp_pkg::RSTPIN_SEL_BIT];
    d.port_e3_in_en = ~c.rstpin[cwdp_pkg::RSTPIN_SEL_BIT];
    d.osc_low_power = c.rstpin[cwdp_pkg::LPOSC_BIT];
    d.portb_analog = {5{c.rstpin[cwdp_pkg::PBAD_BIT]}};
    d.capcomp2_on_c1 = c.rstpin[cwdp_pkg::CCPMX_BIT];
    d.capcomp2_on_b3 = ~c.rstpin[cwdp_pkg::CCPMX_BIT];
    d.debugger_en = ~c.dbgboot[cwdp_pkg::DBG_BIT];
    d.isa_ext_en = c.dbgboot[cwdp_pkg::ISA_EXT_BIT];
    d.icport_en = c.dbgboot[cwdp_pkg::ICPORT_BIT];
    d.boot_words = boot_size(v, bb);
    d.lvp_entry_en = c.dbgboot[cwdp_pkg::LVPROG_BIT];
    d.stack_reset_en = c.dbgboot[cwdp_pkg::STV_BIT];
    d.blk_read_prot = ~c.cp_lo[5:0];
    d.eeprom_read_prot = ~c.cp_hi[cwdp_pkg::HI_D_BIT];
    d.boot_read_prot = ~c.cp_hi[cwdp_pkg::HI_B_BIT];
    d.blk_write_prot = ~c.wr_lo[5:0];
    d.eeprom_write_prot = ~c.wr_hi[cwdp_pkg::HI_D_BIT];
    d.boot_write_prot = ~c.wr_hi[cwdp_pkg::HI_B_BIT];
    d.config_write_prot = ~c.wr_hi[cwdp_pkg::HI_C_BIT];
    d.blk_tblrd_prot = ~c.tb_lo[5:0];
    d.boot_tblrd_prot = ~c.tb_hi[cwdp_pkg::HI_B_BIT];
    return d;
  endfunction : decode

  always_comb
  begin
    logic       bb_locked;
    logic [7:0] wv;
    logic [2:0] src;
    logic [2:0] dst;
    state_nxt = state_r;
    bb_locked = 1'b0;
    wv = cfg_wdata;
    src = tblrd_src_area;
    dst = tblrd_dst_area;
    state_nxt.refused = 1'b0;
    state_nxt.stk = 1'b0;
    state_nxt.wr_ok = 1'b0;
    state_nxt.rd_ok = 1'b0;

    // Any boot or block 0 guard set freezes the boot size field.
    bb_locked = ~state_r.cfg.cp_hi[cwdp_pkg::HI_B_BIT] | ~state_r.cfg.cp_lo[0]
              | ~state_r.cfg.wr_hi[cwdp_pkg::HI_B_BIT] | ~state_r.cfg.wr_lo[0]
              | ~state_r.cfg.tb_hi[cwdp_pkg::HI_B_BIT] | ~state_r.cfg.tb_lo[0];

    unique case (state_r.st)
      cwdp_pkg::CWDP_ST_LOAD:
      begin
        // One cycle after reset release the decoded copy is captured.
        state_nxt.dec = decode(state_r.cfg, mem_variant);
        state_nxt.st = cwdp_pkg::CWDP_ST_RUN;
      end
      cwdp_pkg::CWDP_ST_RUN:
      begin
        // Stored words may change here; decoded outputs other than wdog_run hold until reset.
        if (cfg_wr)
        begin
          if (!state_r.cfg.wr_hi[cwdp_pkg::HI_C_BIT])
          begin
            state_nxt.refused = 1'b1;
          end
          else
          begin
            unique case (cfg_addr)
              cwdp_pkg::OFS_WDOG_HI: state_nxt.cfg.wdog = wv & cwdp_pkg::MSK_WDOG;
              cwdp_pkg::OFS_RSTPIN:  state_nxt.cfg.rstpin = wv & cwdp_pkg::MSK_RSTPIN;
              cwdp_pkg::OFS_DBGBOOT:
              begin
                if (bb_locked)
                begin
                  wv = (wv & ~cwdp_pkg::MSK_BBSZ)
                     | (state_r.cfg.dbgboot & cwdp_pkg::MSK_BBSZ);
                end
                state_nxt.cfg.dbgboot = wv & cwdp_pkg::MSK_DBG;
              end
              cwdp_pkg::OFS_CP_LO:   state_nxt.cfg.cp_lo = wv & cwdp_pkg::MSK_BLK;
              cwdp_pkg::OFS_CP_HI:   state_nxt.cfg.cp_hi = wv & cwdp_pkg::MSK_CP_HI;
              cwdp_pkg::OFS_WR_LO:   state_nxt.cfg.wr_lo = wv & cwdp_pkg::MSK_BLK;
              cwdp_pkg::OFS_WR_HI:   state_nxt.cfg.wr_hi = wv & cwdp_pkg::MSK_WR_HI;
              cwdp_pkg::OFS_TB_LO:   state_nxt.cfg.tb_lo = wv & cwdp_pkg::MSK_BLK;
              cwdp_pkg::OFS_TB_HI:   state_nxt.cfg.tb_hi = wv & cwdp_pkg::MSK_TB_HI;
              default:               state_nxt.refused = 1'b1;
            endcase
          end
        end
        state_nxt.stk = stack_fault & state_r.dec.stack_reset_en;
        state_nxt.wr_ok = prog_wr_req & ~guard_bit(state_r.dec.blk_write_prot,
                          state_r.dec.eeprom_write_prot, state_r.dec.boot_write_prot,
                          prog_wr_area);
        state_nxt.rd_ok = tblrd_req & ((src == dst)
                        | ~guard_bit(state_r.dec.blk_tblrd_prot, 1'b0,
                                     state_r.dec.boot_tblrd_prot, dst));
      end
      default:
      begin
        state_nxt.st = cwdp_pkg::CWDP_ST_LOAD;
      end
    endcase

    // The stored watchdog enable bit and the run-time software enable are both live inputs to the watchdog gate.
    state_nxt.dec.wdog_run = state_r.cfg.wdog[cwdp_pkg::WDOG_ON_BIT]
                           | watchdog_soft_enable;

    if (cfg_rd)
    begin
      unique case (cfg_addr)
        cwdp_pkg::OFS_WDOG_HI: state_nxt.rdata = state_r.cfg.wdog;
        cwdp_pkg::OFS_RSTPIN:  state_nxt.rdata = state_r.cfg.rstpin;
        cwdp_pkg::OFS_DBGBOOT: state_nxt.rdata = state_r.cfg.dbgboot;
        cwdp_pkg::OFS_CP_LO:   state_nxt.rdata = state_r.cfg.cp_lo;
        cwdp_pkg::OFS_CP_HI:   state_nxt.rdata = state_r.cfg.cp_hi;
        cwdp_pkg::OFS_WR_LO:   state_nxt.rdata = state_r.cfg.wr_lo;
        cwdp_pkg::OFS_WR_HI:   state_nxt.rdata = state_r.cfg.wr_hi;
        cwdp_pkg::OFS_TB_LO:   state_nxt.rdata = state_r.cfg.tb_lo;
        cwdp_pkg::OFS_TB_HI:   state_nxt.rdata = state_r.cfg.tb_hi;
        cwdp_pkg::OFS_PART_LO: state_nxt.rdata = {PART_NUMBER[2:0], REVISION};
        cwdp_pkg::OFS_PART_HI: state_nxt.rdata = PART_NUMBER[10:3];
        default:               state_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
      state_r.st <= cwdp_pkg::CWDP_ST_LOAD;
      state_r.cfg.wdog <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_WDOG;
      state_r.cfg.rstpin <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_RSTPIN;
      state_r.cfg.dbgboot <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_DBG;
      state_r.cfg.cp_lo <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_BLK;
      state_r.cfg.cp_hi <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_CP_HI;
      state_r.cfg.wr_lo <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_BLK;
      state_r.cfg.wr_hi <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_WR_HI;
      state_r.cfg.tb_lo <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_BLK;
      state_r.cfg.tb_hi <= cwdp_pkg::RST_ERASED & cwdp_pkg::MSK_TB_HI;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign cfg_rdata = state_r.rdata;
  assign cfg_wr_refused = state_r.refused;
  assign dec = state_r.dec;
  assign prog_wr_ok = state_r.wr_ok;
  assign tblrd_ok = state_r.rd_ok;
  assign stack_reset_req = state_r.stk;

endmodule : cwdp_config_decode

/* File: cwdp_pkg.sv */
package cwdp_pkg;

  // Configuration space word offsets (low byte of the address).
  localparam logic [7:0] OFS_WDOG_HI     = 8'h03;
  localparam logic [7:0] OFS_RSTPIN      = 8'h05;
  localparam logic [7:0] OFS_DBGBOOT     = 8'h06;
  localparam logic [7:0] OFS_CP_LO       = 8'h08;
  localparam logic [7:0] OFS_CP_HI       = 8'h09;
  localparam logic [7:0] OFS_WR_LO       = 8'h0A;
  localparam logic [7:0] OFS_WR_HI       = 8'h0B;
  localparam logic [7:0] OFS_TB_LO       = 8'h0C;
  localparam logic [7:0] OFS_TB_HI       = 8'h0D;
  localparam logic [7:0] OFS_PART_LO     = 8'hFE;
  localparam logic [7:0] OFS_PART_HI     = 8'hFF;

  // Field positions.
  localparam int WDOG_PS_LSB    = 1;
  localparam int WDOG_ON_BIT    = 0;
  localparam int RSTPIN_SEL_BIT = 7;
  localparam int LPOSC_BIT  = 2;
  localparam int PBAD_BIT   = 1;
  localparam int CCPMX_BIT  = 0;
  localparam int DBG_BIT    = 7;
  localparam int ISA_EXT_BIT = 6;
  localparam int ICPORT_BIT  = 5;
  localparam int BBSZ_LSB    = 4;
  localparam int LVPROG_BIT  = 2;
  localparam int STV_BIT    = 0;
  localparam int HI_D_BIT   = 7;
  localparam int HI_B_BIT   = 6;
  localparam int HI_C_BIT   = 5;

  // Masks of implemented bits.
  localparam logic [7:0] MSK_WDOG   = 8'h1F;
  localparam logic [7:0] MSK_RSTPIN = 8'h87;
  localparam logic [7:0] MSK_DBG    = 8'hF5;
  localparam logic [7:0] MSK_BLK    = 8'h3F;
  localparam logic [7:0] MSK_CP_HI  = 8'hC0;
  localparam logic [7:0] MSK_WR_HI  = 8'hE0;
  localparam logic [7:0] MSK_TB_HI  = 8'h40;
  localparam logic [7:0] MSK_BBSZ   = 8'h30;

  // Values after reset: all implemented bits erased to one.
  localparam logic [7:0] RST_ERASED = 8'hFF;

  // Boot block sizes in words.
  localparam logic [12:0] WORDS_4K  = 13'h1000;
  localparam logic [12:0] WORDS_2K  = 13'h0800;
  localparam logic [12:0] WORDS_1K  = 13'h0400;
  localparam logic [12:0] WORDS_512 = 13'h0200;
  localparam logic [12:0] WORDS_256 = 13'h0100;

  typedef enum logic [1:0] {
    CWDP_MEM_LARGE = 2'h0,
    CWDP_MEM_8K    = 2'h1,
    CWDP_MEM_4K    = 2'h2,
    CWDP_MEM_ONE   = 2'h3
  } cwdp_mem_e;

  typedef enum logic [1:0] {
    CWDP_ST_LOAD = 2'b01,
    CWDP_ST_RUN  = 2'b10
  } cwdp_st_e;

  typedef struct packed {
    logic [7:0] wdog;
    logic [7:0] rstpin;
    logic [7:0] dbgboot;
    logic [7:0] cp_lo;
    logic [7:0] cp_hi;
    logic [7:0] wr_lo;
    logic [7:0] wr_hi;
    logic [7:0] tb_lo;
    logic [7:0] tb_hi;
  } cwdp_cfg_s;

  typedef struct packed {
    logic [15:0] wdog_ratio;
    logic        wdog_run;
    logic        ext_reset_en;
    logic        port_e3_in_en;
    logic        osc_low_power;
    logic [4:0]  portb_analog;
    logic        capcomp2_on_c1;
    logic        capcomp2_on_b3;
    logic        debugger_en;
    logic        isa_ext_en;
    logic        icport_en;
    logic [12:0] boot_words;
    logic        lvp_entry_en;
    logic        stack_reset_en;
    logic [5:0]  blk_read_prot;
    logic        eeprom_read_prot;
    logic        boot_read_prot;
    logic [5:0]  blk_write_prot;
    logic        eeprom_write_prot;
    logic        boot_write_prot;
    logic        config_write_prot;
    logic [5:0]  blk_tblrd_prot;
    logic        boot_tblrd_prot;
  } cwdp_dec_s;

endpackage : cwdp_pkg

/* File: cwdp_monitor.sv */
`timescale 1ns/1ns
module cwdp_monitor #(
  parameter logic [10:0] PART_NUMBER = 11'h155, // Arbitrary neutral value.
  parameter logic [4:0]  REVISION    = 5'h01    // Arbitrary neutral value.
) (
  input wire logic                 sys_clk,              // System clock
  input wire logic                 rst_n,                // Async reset, low
  input wire cwdp_pkg::cwdp_mem_e  mem_variant,          // Variant strap
  input wire logic                 cfg_wr,               // Write strobe
  input wire logic                 cfg_rd,               // Read strobe
  input wire logic [7:0]           cfg_addr,             // Word offset
  input wire logic [7:0]           cfg_wdata,            // Write data
  input wire logic                 watchdog_soft_enable, // Software watchdog bit
  input wire logic                 stack_fault,          // Stack event
  input wire logic                 prog_wr_req,          // Memory write request
  input wire logic [2:0]           prog_wr_area,         // Write area
  input wire logic                 tblrd_req,            // Table read request
  input wire logic [2:0]           tblrd_src_area,       // Reading area
  input wire logic [2:0]           tblrd_dst_area,       // Read area
  input wire logic [7:0]           cfg_rdata,            // Read data
  input wire logic                 cfg_wr_refused,       // Refused pulse
  input wire cwdp_pkg::cwdp_dec_s  dec,                  // Decoded settings
  input wire logic                 prog_wr_ok,           // Write allowed
  input wire logic                 tblrd_ok,             // Table read allowed
  input wire logic                 stack_reset_req       // Stack reset pulse
);
  // Counts edges since reset release so the load cycle is kept out of checks.
  logic [1:0] run_cnt_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      run_cnt_r <= 2'h0;
    else if (run_cnt_r != 2'h3)
      run_cnt_r <= run_cnt_r + 2'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_refuse_cause: assert property (cfg_wr_refused |-> $past(cfg_wr))
    else $error("refused pulse without a write");
  a_id_write_lock: assert property (cfg_wr && (cfg_addr == 8'hFE || cfg_addr == 8'hFF)
    |=> cfg_wr_refused) else $error("identification write not refused");
  a_part_upper: assert property (cfg_rd && cfg_addr == 8'hFF
    |=> cfg_rdata == PART_NUMBER[10:3]) else $error("part number upper wrong");
  a_part_lower: assert property (cfg_rd && cfg_addr == 8'hFE
    |=> cfg_rdata == {PART_NUMBER[2:0], REVISION}) else $error("part lower or revision wrong");
  a_rdata_hold: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata))
    else $error("read data moved without a read");
  a_dec_frozen: assert property (run_cnt_r == 2'h3 |-> $stable(dec.boot_words)
    && $stable(dec.wdog_ratio) && $stable(dec.blk_write_prot)) else $error("decoded word moved");
  a_ratio_onehot: assert property (run_cnt_r != 2'h0 |-> $onehot(dec.wdog_ratio))
    else $error("postscale ratio not a power of two");
  a_pin_exclusive: assert property (run_cnt_r != 2'h0 |->
    dec.ext_reset_en != dec.port_e3_in_en && dec.capcomp2_on_c1 != dec.capcomp2_on_b3)
    else $error("shared pin given two functions");
  a_stack_cause: assert property (stack_reset_req |-> $past(stack_fault)
    && dec.stack_reset_en) else $error("stack reset without cause");
  a_stack_pulse: assert property (run_cnt_r == 2'h3 && stack_fault && dec.stack_reset_en
    |=> stack_reset_req) else $error("stack fault gave no reset");
  a_wdog_forced: assert property (run_cnt_r[1] && $past(watchdog_soft_enable)
    |-> dec.wdog_run) else $error("software watchdog enable ignored");
  a_prog_cause: assert property (prog_wr_ok |-> $past(prog_wr_req))
    else $error("write grant without request");
  a_tblrd_cause: assert property (tblrd_ok |-> $past(tblrd_req))
    else $error("table read grant without request");
endmodule : cwdp_monitor

/* File: cwdp_config_decode_tb.sv */
`timescale 1ns/1ns
module cwdp_config_decode_tb;
  localparam logic [10:0] PART = 11'h2C9; // Arbitrary identification value.
  localparam logic [4:0]  REV  = 5'h0A;   // Arbitrary identification value.
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  cwdp_pkg::cwdp_mem_e mem_variant = cwdp_pkg::CWDP_MEM_LARGE;
  logic                cfg_wr = 1'b0;
  logic                cfg_rd = 1'b0;
  logic [7:0]          cfg_addr = 8'h00;
  logic [7:0]          cfg_wdata = 8'h00;
  logic                soft_en = 1'b0;
  logic                stack_fault = 1'b0;
  logic                prog_wr_req = 1'b0;
  logic [2:0]          prog_wr_area = 3'h0;
  logic                tblrd_req = 1'b0;
  logic [2:0]          tblrd_src = 3'h0;
  logic [2:0]          tblrd_dst = 3'h7;
  logic [7:0]          cfg_rdata;
  logic                cfg_wr_refused;
  cwdp_pkg::cwdp_dec_s dec;
  logic                prog_wr_ok;
  logic                tblrd_ok;
  logic                stack_reset_req;
  int                  err_total = 0;
  int                  checked = 0;
  // Table order puts the guard word last, since it locks further writes.
  logic [7:0] ofs [9] = '{8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0B};
  logic [7:0] msk [9] = '{8'h1F, 8'h87, 8'hF5, 8'h3F, 8'hC0, 8'h3F, 8'h3F, 8'h40, 8'hE0};

  always #4 sys_clk = ~sys_clk;

  cwdp_config_decode #(.PART_NUMBER(PART), .REVISION(REV)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .mem_variant(mem_variant), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .watchdog_soft_enable(soft_en), .stack_fault(stack_fault), .prog_wr_req(prog_wr_req),
    .prog_wr_area(prog_wr_area), .tblrd_req(tblrd_req), .tblrd_src_area(tblrd_src),
    .tblrd_dst_area(tblrd_dst), .cfg_rdata(cfg_rdata), .cfg_wr_refused(cfg_wr_refused),
    .dec(dec), .prog_wr_ok(prog_wr_ok), .tblrd_ok(tblrd_ok), .stack_reset_req(stack_reset_req)
  );

  task automatic finish_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check_dec(input cwdp_pkg::cwdp_dec_s exp);
    checked++;
    if (dec !== exp)
    begin
      err_total++;
      $display("[ERR] dec expected %h seen %h", exp, dec);
    end
  endtask : check_dec

  // Erased words decode to this; only the boot size depends on the variant.
  function automatic cwdp_pkg::cwdp_dec_s exp_dec(input int v);
    cwdp_pkg::cwdp_dec_s d;
    d = '0;
    d.wdog_ratio = 16'h8000;
    d.wdog_run = 1'b1;
    d.ext_reset_en = 1'b1;
    d.osc_low_power = 1'b1;
    d.portb_analog = 5'h1F;
    d.capcomp2_on_c1 = 1'b1;
    d.isa_ext_en = 1'b1;
    d.icport_en = 1'b1;
    d.lvp_entry_en = 1'b1;
    d.stack_reset_en = 1'b1;
    d.boot_words = (v == 0) ? cwdp_pkg::WORDS_4K : (v == 1) ? cwdp_pkg::WORDS_1K :
                   (v == 2) ? cwdp_pkg::WORDS_512 : cwdp_pkg::WORDS_2K;
    return d;
  endfunction : exp_dec

  task automatic do_reset(input int v);
    rst_n = 1'b0;
    mem_variant = cwdp_pkg::cwdp_mem_e'(v[1:0]);
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic refuse);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge sys_clk);
    #1 cfg_wr = 1'b0;
    check8("cfg_wr_refused", {7'h0, refuse}, {7'h0, cfg_wr_refused});
    @(posedge sys_clk);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge sys_clk);
    #1 cfg_rd = 1'b0;
    check8("cfg_rdata", exp, cfg_rdata);
    @(posedge sys_clk);
    #1;
  endtask : rd_reg

  initial
  begin
    for (int v = 0; v < 4; v++)
    begin
      do_reset(v);
      check_dec(exp_dec(v));
    end
    for (int i = 0; i < 9; i++)
      rd_reg(ofs[i], msk[i]);
    rd_reg(8'hFF, PART[10:3]);
    rd_reg(8'hFE, {PART[2:0], REV});
    wr_reg(8'hFE, 8'h00, 1'b1);
    wr_reg(8'hFF, 8'h00, 1'b1);
    wr_reg(8'h20, 8'h00, 1'b1);
    rd_reg(8'hFE, {PART[2:0], REV});
    // The request stays up across areas so no edge sees it dropped and raised at once.
    prog_wr_req = 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      prog_wr_area = a[2:0];
      @(posedge sys_clk);
      #1 check8("prog_wr_ok", 8'h01, {7'h0, prog_wr_ok});
    end
    prog_wr_req = 1'b0;
    tblrd_req = 1'b1;
    @(posedge sys_clk);
    #1 tblrd_req = 1'b0;
    check8("tblrd_ok", 8'h01, {7'h0, tblrd_ok});
    stack_fault = 1'b1;
    @(posedge sys_clk);
    #1 stack_fault = 1'b0;
    check8("stack_reset_req", 8'h01, {7'h0, stack_reset_req});
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(ofs[i], 8'h5A, 1'b0);
      rd_reg(ofs[i], 8'h5A & msk[i]);
      if (i == 3)
      begin
        // Block 0 read guard is now on, so the boot size field must hold.
        wr_reg(8'h06, 8'hCF, 1'b0);
        rd_reg(8'h06, 8'hD5);
      end
    end
    wr_reg(8'h03, 8'h00, 1'b1);
    rd_reg(8'h03, 8'h1A);
    soft_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check_dec(exp_dec(3));
    soft_en = 1'b0;
    do_reset(0);
    rd_reg(8'h03, 8'h1F);
    finish_test();
  end

  initial
  begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule : cwdp_config_decode_tb

bind cwdp_config_decode cwdp_monitor #(.PART_NUMBER(PART_NUMBER), .REVISION(REVISION)) u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .mem_variant(mem_variant), .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .watchdog_soft_enable(watchdog_soft_enable), .stack_fault(stack_fault),
  .prog_wr_req(prog_wr_req), .prog_wr_area(prog_wr_area), .tblrd_req(tblrd_req),
  .tblrd_src_area(tblrd_src_area), .tblrd_dst_area(tblrd_dst_area), .cfg_rdata(cfg_rdata),
  .cfg_wr_refused(cfg_wr_refused), .dec(dec), .prog_wr_ok(prog_wr_ok), .tblrd_ok(tblrd_ok),
  .stack_reset_req(stack_reset_req)
);
